/* File: eppl_cycle_engine.sv */
// What this block does
// - Idle port lines follow the control register
// - Time each cycle; flag beyond ten microseconds
// - Time-out aborts cycle and sets status bit 0
// - Hold bus stalled while handshake stays low
// - Write asserts cycle strobe and, with direction bit clear, drives byte at the same edge
// - Stall ends on handshake release or time-out
// - Host release ends strobe, byte stays latched
// - Read strobe only with bus released, direction high
// - Host release ends strobe; peripheral releases bus
// - Direction and data change only between cycles
// - Active-low write, data and address strobes
// - Active-low peripheral reset output
// - Peripheral interrupt passed through uninverted
// - Direction output high only for input/read
// - Only write line overridable during a cycle
// - Direction bit selects output or input mode, except in printer mode, which always drives out
// - Offset 3 address cycles, 4-7 data cycles
module eppl_cycle_engine
#(
  parameter int TMO_CYC = eppl_pkg::EPPL_TMO_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [7:0] i_port_side_bus,
  output logic [7:0] o_port_side_bus,
  output logic o_port_side_bus_oe,
  output logic o_xfer_dir_out_n,
  output logic o_data_cycle_strobe_n,
  output logic o_addr_cycle_strobe_n,
  output logic o_periph_reset_n,
  output logic o_bus_direction_out,
  input wire logic i_periph_handshake_n,
  input wire logic i_periph_irq_in,
  output logic o_periph_irq,
  input wire logic i_busy,
  input wire logic i_ack_n,
  input wire logic i_paper_end,
  input wire logic i_select,
  input wire logic i_error_n
);

  import eppl_pkg::*;

  eppl_state_s q_r;
  eppl_state_s q_nxt;
  logic [3:0] idx;
  logic req;
  logic epp_port;
  logic wd_start;
  logic wd_run;
  logic wd_expired;

  // True when an index selects one of the EPP cycle ports
  function automatic logic is_epp_port(input logic [3:0] i);
    is_epp_port = (i >= EPPL_IDX_ADDR_PORT) && (i <= EPPL_IDX_DATA_PORT3);
  endfunction : is_epp_port

  // Direction seen on the port bus; printer mode always drives out
  function automatic logic bus_dir(input logic [1:0] mode, input logic [5:0] ctrl,
                                   input logic rd_cyc);
    bus_dir = ((mode != EPPL_MODE_PRINTER) && ctrl[EPPL_CTRL_DIR]) || rd_cyc;
  endfunction : bus_dir

  // Request decode
  always_comb
  begin
    idx = i_avs_address[5:2];
    req = i_avs_read || i_avs_write;
    epp_port = is_epp_port(idx) && (q_r.mode == EPPL_MODE_EPP);
    wd_start = (q_r.st == EPPL_ST_IDLE) && req && epp_port;
    wd_run = (q_r.st == EPPL_ST_ACTIVE);
  end

  // Cycle timer runs on the system clock; a hung peripheral cannot lock the bus
  eppl_watchdog #(
    .TMO_CYC(TMO_CYC)
  ) u_watchdog (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(wd_start),
    .i_run(wd_run),
    .o_expired(wd_expired)
  );

  // Next-state logic for the whole block
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.irq = i_periph_irq_in;
    q_nxt.prst_n = q_r.ctrl[EPPL_CTRL_INIT];
    q_nxt.waitreq = 1'b1;
    case (q_r.st)
      EPPL_ST_IDLE:
      begin
        if (req && epp_port)
        begin
          // Start of an EPP cycle; byte and direction settle with the strobe edge
          q_nxt.st = EPPL_ST_ACTIVE;
          q_nxt.cyc_read = i_avs_read;
          q_nxt.cyc_addr = (idx == EPPL_IDX_ADDR_PORT);
          if (i_avs_write && i_avs_byteenable[0])
          begin
            q_nxt.out_byte = i_avs_writedata[7:0];
          end
          q_nxt.dir = bus_dir(q_r.mode, q_r.ctrl, i_avs_read);
          q_nxt.oe = !bus_dir(q_r.mode, q_r.ctrl, i_avs_read);
          if (idx == EPPL_IDX_ADDR_PORT)
          begin
            q_nxt.astb_n = 1'b0;
          end
          else
          begin
            q_nxt.dstb_n = 1'b0;
          end
        end
        else if (req)
        begin
          // Plain register access answers in one cycle
          q_nxt.st = EPPL_ST_ACK;
          q_nxt.waitreq = 1'b0;
          q_nxt.rdata = 32'h0000_0000;
          case (idx)
            EPPL_IDX_DATA:
            begin
              q_nxt.rdata[7:0] = q_r.oe ? q_r.out_byte : i_port_side_bus;
              if (i_avs_write && i_avs_byteenable[0])
              begin
                q_nxt.out_byte = i_avs_writedata[7:0];
              end
            end
            EPPL_IDX_STATUS:
            begin
              q_nxt.rdata[EPPL_STAT_BUSY_N] = !i_busy;
              q_nxt.rdata[EPPL_STAT_ACK_N] = i_ack_n;
              q_nxt.rdata[EPPL_STAT_PAPER] = i_paper_end;
              q_nxt.rdata[EPPL_STAT_SELECT] = i_select;
              q_nxt.rdata[EPPL_STAT_ERR_N] = i_error_n;
              q_nxt.rdata[EPPL_STAT_TMO] = q_r.tmo_flag;
              if (i_avs_write && i_avs_byteenable[0] && i_avs_writedata[EPPL_STAT_TMO])
              begin
                q_nxt.tmo_flag = 1'b0;
              end
            end
            EPPL_IDX_CTRL:
            begin
              q_nxt.rdata[5:0] = q_r.ctrl; // Bits 7:6 read as zero
              if (i_avs_write && i_avs_byteenable[0])
              begin
                q_nxt.ctrl = i_avs_writedata[5:0];
              end
            end
            EPPL_IDX_MODE:
            begin
              q_nxt.rdata[1:0] = q_r.mode;
              if (i_avs_write && i_avs_byteenable[0])
              begin
                q_nxt.mode = i_avs_writedata[1:0];
              end
            end
            default:
            begin
              q_nxt.rdata = 32'h0000_0000; // Unmapped or EPP port outside EPP mode
            end
          endcase
        end
      end
      EPPL_ST_ACTIVE:
      begin
        if (wd_expired)
        begin
          // Abort: drop the strobe now and let the host finish the access
          q_nxt.tmo_flag = 1'b1;
          q_nxt.dstb_n = 1'b1;
          q_nxt.astb_n = 1'b1;
          q_nxt.rdata = 32'h0000_0000;
          q_nxt.waitreq = 1'b0;
          q_nxt.st = EPPL_ST_ACK;
        end
        else if (i_periph_handshake_n)
        begin
          // Handshake released: peripheral byte is valid, host may complete
          q_nxt.rdata = {24'h00_0000, i_port_side_bus};
          q_nxt.waitreq = 1'b0;
          q_nxt.st = EPPL_ST_ACK;
        end
      end
      EPPL_ST_ACK:
      begin
        // Host strobe is released at this edge; end the port strobe then
        q_nxt.dstb_n = 1'b1;
        q_nxt.astb_n = 1'b1;
        q_nxt.cyc_read = 1'b0;
        q_nxt.st = EPPL_ST_IDLE;
      end
      default:
      begin
        q_nxt.st = EPPL_ST_IDLE;
      end
    endcase

    // Between cycles the port lines follow the control register
    if (q_nxt.st == EPPL_ST_IDLE)
    begin
      q_nxt.dstb_n = !q_nxt.ctrl[EPPL_CTRL_AUTOFD];
      q_nxt.astb_n = !q_nxt.ctrl[EPPL_CTRL_SELIN];
      q_nxt.dir = bus_dir(q_nxt.mode, q_nxt.ctrl, 1'b0);
      q_nxt.oe = !q_nxt.dir;
    end

    // Write line: low for write direction in EPP mode, and the strobe bit may force it
    // even mid-cycle, since it shares the pin with the standard strobe
    q_nxt.wr_n = !q_nxt.ctrl[EPPL_CTRL_STROBE] &&
                 !((q_nxt.mode == EPPL_MODE_EPP) && !q_nxt.ctrl[EPPL_CTRL_DIR]);
  end

  // Single state register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q_r.st <= EPPL_ST_IDLE;
      q_r.ctrl <= EPPL_CTRL_RESET;
      q_r.mode <= EPPL_MODE_RESET;
      q_r.tmo_flag <= 1'b0;
      q_r.cyc_read <= 1'b0;
      q_r.cyc_addr <= 1'b0;
      q_r.out_byte <= EPPL_BYTE_RESET;
      q_r.rdata <= 32'h0000_0000;
      q_r.waitreq <= 1'b1;
      q_r.dstb_n <= 1'b1;
      q_r.astb_n <= 1'b1;
      q_r.wr_n <= 1'b1;
      q_r.dir <= 1'b0;
      q_r.oe <= 1'b1;
      q_r.prst_n <= 1'b1;
      q_r.irq <= 1'b0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from the state register
  assign o_avs_readdata = q_r.rdata;
  assign o_avs_waitrequest = q_r.waitreq;
  assign o_port_side_bus = q_r.out_byte;
  assign o_port_side_bus_oe = q_r.oe;
  assign o_xfer_dir_out_n = q_r.wr_n;
  assign o_data_cycle_strobe_n = q_r.dstb_n;
  assign o_addr_cycle_strobe_n = q_r.astb_n;
  assign o_periph_reset_n = q_r.prst_n;
  assign o_bus_direction_out = q_r.dir;
  assign o_periph_irq = q_r.irq;

endmodule : eppl_cycle_engine

/* File: eppl_pkg.sv */
package eppl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] EPPL_IDX_DATA = 4'h0;
  localparam logic [3:0] EPPL_IDX_STATUS = 4'h1;
  localparam logic [3:0] EPPL_IDX_CTRL = 4'h2;
  localparam logic [3:0] EPPL_IDX_ADDR_PORT = 4'h3;
  localparam logic [3:0] EPPL_IDX_DATA_PORT0 = 4'h4;
  localparam logic [3:0] EPPL_IDX_DATA_PORT3 = 4'h7;
  localparam logic [3:0] EPPL_IDX_MODE = 4'h8;

  // Control register fields
  localparam int EPPL_CTRL_STROBE = 0;
  localparam int EPPL_CTRL_AUTOFD = 1;
  localparam int EPPL_CTRL_INIT = 2;
  localparam int EPPL_CTRL_SELIN = 3;
  localparam int EPPL_CTRL_IRQE = 4;
  localparam int EPPL_CTRL_DIR = 5;
  localparam logic [5:0] EPPL_CTRL_RESET = 6'h04;

  // Status register fields
  localparam int EPPL_STAT_TMO = 0;
  localparam int EPPL_STAT_ERR_N = 3;
  localparam int EPPL_STAT_SELECT = 4;
  localparam int EPPL_STAT_PAPER = 5;
  localparam int EPPL_STAT_ACK_N = 6;
  localparam int EPPL_STAT_BUSY_N = 7;

  // Port modes held in the mode register
  localparam logic [1:0] EPPL_MODE_PRINTER = 2'h0;
  localparam logic [1:0] EPPL_MODE_BIDIR = 2'h1;
  localparam logic [1:0] EPPL_MODE_EPP = 2'h2;
  localparam logic [1:0] EPPL_MODE_RESET = 2'h0;

  // Cycle watchdog timing
  localparam int EPPL_CLK_MHZ = 100;
  localparam int EPPL_TMO_US = 10;
  localparam int EPPL_TMO_CYC = EPPL_TMO_US * EPPL_CLK_MHZ;
  localparam int EPPL_TMO_W = 11;

  localparam logic [7:0] EPPL_BYTE_RESET = 8'h00;

  typedef enum logic [1:0]
  {
    EPPL_ST_IDLE = 2'b00,
    EPPL_ST_ACTIVE = 2'b01,
    EPPL_ST_ACK = 2'b10
  } eppl_state_e;

  typedef struct packed
  {
    eppl_state_e st;
    logic [5:0] ctrl;
    logic [1:0] mode;
    logic tmo_flag;
    logic cyc_read;
    logic cyc_addr;
    logic [7:0] out_byte;
    logic [31:0] rdata;
    logic waitreq;
    logic dstb_n;
    logic astb_n;
    logic wr_n;
    logic dir;
    logic oe;
    logic prst_n;
    logic irq;
  } eppl_state_s;

endpackage : eppl_pkg

/* File: eppl_watchdog.sv */
module eppl_watchdog
#(
  parameter int TMO_CYC = eppl_pkg::EPPL_TMO_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_run,
  output logic o_expired
);

  import eppl_pkg::*;

  typedef struct packed
  {
    logic [EPPL_TMO_W-1:0] cnt;
    logic expired;
  } eppl_wd_s;

  localparam logic [EPPL_TMO_W-1:0] PRESET = EPPL_TMO_W'(TMO_CYC);

  eppl_wd_s q_r;
  eppl_wd_s q_nxt;

  // Preset on each new host strobe, then count down while the cycle runs
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.expired = 1'b0;
    if (i_start)
    begin
      q_nxt.cnt = PRESET;
    end
    else if (i_run)
    begin
      if (q_r.cnt <= EPPL_TMO_W'(1))
      begin
        q_nxt.expired = 1'b1;
      end
      else
      begin
        q_nxt.cnt = q_r.cnt - EPPL_TMO_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q_r <= '0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign o_expired = q_r.expired;

endmodule : eppl_watchdog

/* File: eppl_chk.sv */
module eppl_chk
#(
  parameter int TMO_CYC = eppl_pkg::EPPL_TMO_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest,
  input wire logic [7:0] o_port_side_bus,
  input wire logic o_port_side_bus_oe,
  input wire logic o_xfer_dir_out_n,
  input wire logic o_data_cycle_strobe_n,
  input wire logic o_addr_cycle_strobe_n,
  input wire logic o_bus_direction_out,
  input wire logic i_periph_handshake_n,
  input wire logic i_periph_irq_in,
  input wire logic o_periph_irq
);
  logic epp;
  logic stb;
  logic [15:0] cnt_r;
  // Request to the address or data ports, and either cycle strobe active
  assign epp = (i_avs_read || i_avs_write) && i_avs_address[5:2] inside {[4'h3:4'h7]};
  assign stb = !o_data_cycle_strobe_n || !o_addr_cycle_strobe_n;
  // Stall length; kept apart from the watchdog so a time-out is not misread
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      cnt_r <= 16'h0000;
    else
      cnt_r <= (epp && stb && !i_periph_handshake_n) ? cnt_r + 16'h0001 : 16'h0000;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_wait_release: assert property (epp && stb && i_periph_handshake_n && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("No answer after handshake release");
  a_stall_hold: assert property (epp && cnt_r != 16'h0000 && cnt_r < TMO_CYC - 5
    |-> o_avs_waitrequest) else $error("Answer given while peripheral busy");
  a_strobe_end: assert property (epp && stb && !o_avs_waitrequest |=> !stb)
    else $error("Cycle strobe held after host release");
  a_write_drive: assert property (i_avs_write && epp && stb |->
    o_port_side_bus == i_avs_writedata[7:0] && o_port_side_bus_oe && !o_xfer_dir_out_n)
    else $error("Write cycle without byte or write line");
  a_read_release: assert property (i_avs_read && epp && stb
    |-> !o_port_side_bus_oe && o_bus_direction_out && o_xfer_dir_out_n)
    else $error("Read strobe with bus driven");
  a_strobe_select: assert property (epp |-> (i_avs_address[5:2] == 4'h3) ?
    o_data_cycle_strobe_n : o_addr_cycle_strobe_n) else $error("Wrong cycle strobe");
  a_irq_pass: assert property ($rose(i_periph_irq_in) |=> $rose(o_periph_irq))
    else $error("Interrupt not passed through");
  a_answer_once: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("Answer longer than one cycle");
endmodule : eppl_chk

bind eppl_cycle_engine eppl_chk #(.TMO_CYC(TMO_CYC)) chk_u (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .o_port_side_bus(o_port_side_bus),
  .o_port_side_bus_oe(o_port_side_bus_oe),
  .o_xfer_dir_out_n(o_xfer_dir_out_n),
  .o_data_cycle_strobe_n(o_data_cycle_strobe_n),
  .o_addr_cycle_strobe_n(o_addr_cycle_strobe_n),
  .o_bus_direction_out(o_bus_direction_out),
  .i_periph_handshake_n(i_periph_handshake_n),
  .i_periph_irq_in(i_periph_irq_in),
  .o_periph_irq(o_periph_irq)
);

/* File: eppl_periph_model.sv */
module eppl_periph_model
(
  input wire logic i_clk,
  input wire logic i_dstb_n,
  input wire logic i_astb_n,
  input wire logic i_dir,
  input wire logic [7:0] i_rbyte,
  input wire logic [7:0] i_wbyte,
  input wire logic [15:0] i_dly,
  output logic o_hs_n,
  output logic [7:0] o_bus,
  output logic [7:0] o_got
);
  logic [15:0] n_r = 16'h0000;
  initial
  begin
    o_hs_n = 1'h0;
    o_bus = 8'h5A;
    o_got = 8'h00;
  end
  // Busy for i_dly cycles per strobe; a released bus toggles so no stale byte lingers
  always @(posedge i_clk)
  begin
    if (!i_dstb_n || !i_astb_n)
    begin
      if (n_r == i_dly)
        o_hs_n <= 1'h1;
      else
        n_r <= n_r + 16'h0001;
      if (!i_dir)
        o_got <= i_wbyte;
      o_bus <= i_dir ? i_rbyte : ~o_bus;
    end
    else
    begin
      n_r <= 16'h0000;
      o_hs_n <= 1'h0;
      o_bus <= ~o_bus;
    end
  end
endmodule : eppl_periph_model

/* File: eppl_cycle_engine_tb_top.sv */
module eppl_cycle_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TMO = 20;
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_avs_read = 1'h0, i_avs_write = 1'h0;
  logic i_periph_irq_in = 1'h0, i_busy = 1'h0, i_ack_n = 1'h1, i_paper_end = 1'h0;
  logic i_select = 1'h1, i_error_n = 1'h0, i_periph_handshake_n;
  logic [5:0] i_avs_address = 6'h00;
  logic [31:0] i_avs_writedata = 32'h00000000, o_avs_readdata, q;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic o_avs_waitrequest, o_port_side_bus_oe, o_xfer_dir_out_n, o_data_cycle_strobe_n;
  logic o_addr_cycle_strobe_n, o_periph_reset_n, o_bus_direction_out, o_periph_irq;
  logic [7:0] o_port_side_bus, i_port_side_bus, mbus, got, rb = 8'h00;
  logic [15:0] dly = 16'h0003;
  int n_mismatch = 0, check_count = 0;
  time t0;
  initial
    forever #5 i_clk = ~i_clk;
  eppl_cycle_engine #(.TMO_CYC(TMO)) dut_u (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_port_side_bus(i_port_side_bus),
    .o_port_side_bus(o_port_side_bus),
    .o_port_side_bus_oe(o_port_side_bus_oe),
    .o_xfer_dir_out_n(o_xfer_dir_out_n),
    .o_data_cycle_strobe_n(o_data_cycle_strobe_n),
    .o_addr_cycle_strobe_n(o_addr_cycle_strobe_n),
    .o_periph_reset_n(o_periph_reset_n),
    .o_bus_direction_out(o_bus_direction_out),
    .i_periph_handshake_n(i_periph_handshake_n),
    .i_periph_irq_in(i_periph_irq_in),
    .o_periph_irq(o_periph_irq),
    .i_busy(i_busy),
    .i_ack_n(i_ack_n),
    .i_paper_end(i_paper_end),
    .i_select(i_select),
    .i_error_n(i_error_n)
  );
  eppl_periph_model pm_u (.i_clk, .i_dstb_n(o_data_cycle_strobe_n),
    .i_astb_n(o_addr_cycle_strobe_n), .i_dir(o_bus_direction_out), .i_rbyte(rb),
    .i_wbyte(o_port_side_bus), .i_dly(dly), .o_hs_n(i_periph_handshake_n), .o_bus(mbus),
    .o_got(got));
  // Shared port wire: whoever enables drives it
  assign i_port_side_bus = o_port_side_bus_oe ? o_port_side_bus : mbus;
  // Read data taken from the register bus
  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: read data %h expected %h", $time, g, e);
    end
  endtask : chk_data
  // Levels seen on the block's pins
  task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: pins %h expected %h", $time, g, e);
    end
  endtask : chk_pin
  // Request rises after an edge and stands until the edge that sees waitrequest low
  task automatic acc(input logic w, input logic [3:0] x, input logic [7:0] d);
    @(posedge i_clk);
    i_avs_address <= {x, 2'h0};
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= {24'h000000, d};
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'h0)
      @(posedge i_clk);
    q = o_avs_readdata;
    i_avs_write <= 1'h0;
    i_avs_read <= 1'h0;
  endtask : acc
  task automatic wr(input logic [3:0] x, input logic [7:0] d);
    acc(1'h1, x, d);
  endtask : wr
  task automatic rd(input logic [3:0] x);
    acc(1'h0, x, 8'h00);
  endtask : rd
  // Values read just after an edge are those that stood before it
  task automatic settle;
    repeat (2) @(posedge i_clk);
  endtask : settle
  task automatic t_regs;
    rd(4'h2);
    chk_data(q, 32'h00000004);
    chk_pin(o_periph_reset_n, 1'h1);
    i_avs_byteenable <= 4'h0;
    wr(4'h2, 8'h00);
    i_avs_byteenable <= 4'hF;
    rd(4'h2);
    chk_data(q, 32'h00000004);
    wr(4'h2, 8'h00);
    settle();
    chk_pin(o_periph_reset_n, 1'h0);
    wr(4'h2, 8'h24);
    settle();
    chk_pin(o_bus_direction_out, 1'h0);
    wr(4'h2, 8'h04);
    rd(4'h1);
    chk_data(q, 32'h000000D0);
    rd(4'h9);
    chk_data(q, 32'h00000000);
  endtask : t_regs
  // Bidirectional mode: idle lines follow control bits
  task automatic t_idle;
    wr(4'h8, 8'h01);
    wr(4'h2, 8'h2A);
    settle();
    chk_pin({o_data_cycle_strobe_n, o_addr_cycle_strobe_n}, 2'h0);
    chk_pin(o_bus_direction_out, 1'h1);
    wr(4'h2, 8'h00);
    settle();
    chk_pin({o_data_cycle_strobe_n, o_addr_cycle_strobe_n}, 2'h3);
    chk_pin(o_bus_direction_out, 1'h0);
    rb <= 8'h77;
    rd(4'h4);
    chk_data(q, 32'h00000000);
  endtask : t_idle
  // Writes to every EPP port in turn, settling after each, with a slow peripheral
  task automatic t_write;
    wr(4'h8, 8'h02);
    for (int i = 3; i < 8; i++)
    begin
      wr(i[3:0], 8'hA0 | i[7:0]);
      chk_pin(got, 8'hA0 | i[7:0]);
      settle();
      chk_pin(o_port_side_bus, 8'hA0 | i[7:0]);
    end
  endtask : t_write
  // Strobe bit forces the write line; then reads with growing peripheral delay
  task automatic t_read;
    wr(4'h2, 8'h21);
    settle();
    chk_pin(o_xfer_dir_out_n, 1'h0);
    wr(4'h2, 8'h20);
    settle();
    chk_pin({o_xfer_dir_out_n, o_bus_direction_out, o_port_side_bus_oe}, 3'h6);
    for (int i = 3; i < 8; i++)
    begin
      dly <= 16'(i - 3);
      rb <= 8'h50 | i[7:0];
      rd(i[3:0]);
      chk_data(q, 32'h00000050 | i);
    end
  endtask : t_read
  // Stuck handshake: abort, sticky flag, clear, then a fresh cycle
  task automatic t_tmo;
    dly <= 16'hFFFF;
    t0 = $time;
    rd(4'h4);
    chk_data(q, 32'h00000000);
    chk_pin(($time - t0) / 10 >= TMO, 1'h1);
    chk_pin(($time - t0) / 10 <= TMO + 5, 1'h1);
    rd(4'h1);
    chk_data(q, 32'h000000D1);
    rd(4'h1);
    chk_data(q, 32'h000000D1);
    wr(4'h1, 8'h01);
    rd(4'h1);
    chk_data(q, 32'h000000D0);
    dly <= 16'h000C;
    rb <= 8'h3C;
    rd(4'h5);
    chk_data(q, 32'h0000003C);
  endtask : t_tmo
  task automatic t_irq;
    i_periph_irq_in <= 1'h1;
    settle();
    chk_pin(o_periph_irq, 1'h1);
    @(posedge i_clk);
    i_periph_irq_in <= 1'h0;
    settle();
    chk_pin(o_periph_irq, 1'h0);
  endtask : t_irq
  // Mid-run reset: write, strobe, reset and direction lines are back at idle levels two edges later
  task automatic t_rst;
    wr(4'h2, 8'h2B);
    i_rst_n <= 1'h0;
    settle();
    chk_pin({o_xfer_dir_out_n, o_data_cycle_strobe_n, o_addr_cycle_strobe_n,
             o_periph_reset_n, o_bus_direction_out}, 5'h1E);
    i_rst_n <= 1'h1;
    rd(4'h2);
    chk_data(q, 32'h00000004);
  endtask : t_rst
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'h1;
    t_regs();
    t_idle();
    t_write();
    t_read();
    t_tmo();
    t_irq();
    t_rst();
    end_sim();
  end
  // Whole run is a few hundred cycles; this is far beyond it
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    end_sim();
  end
endmodule : eppl_cycle_engine_tb_top
